/* rtl/pcsr_pkg.sv */
// package for the port charger status register slice
// assumes one 200 MHz core clock and a byte-wide register port from the serial engine
package pcsr_pkg;
    // register offsets on the internal register port
    localparam logic [7:0] LEGACY_ACCEPT_OFS = 8'h13; // read-only profile acceptance
    localparam logic [7:0] PIN_STATE_OFS = 8'h14; // read-only pins and power state
    localparam logic [7:0] GENERAL_CFG_OFS = 8'h15;
    localparam logic [7:0] EMULATION_CFG_OFS = 8'h16;
    localparam logic [7:0] SWITCH_CFG_OFS = 8'h17;
    localparam logic [7:0] ATTACH_CFG_OFS = 8'h18;
    localparam logic [7:0] DATA_SW_CFG_OFS = 8'h25;
    // reset values of the configuration registers
    localparam logic [7:0] GENERAL_CFG_RST = 8'h01;
    localparam logic [7:0] EMULATION_CFG_RST = 8'h8c;
    localparam logic [7:0] SWITCH_CFG_RST = 8'h04;
    localparam logic [7:0] ATTACH_CFG_RST = 8'h46;
    localparam logic [7:0] DATA_SW_CFG_RST = 8'h14;
    // number of legacy profiles, one acceptance bit each
    localparam int LEGACY_COUNT = 7;
    // pin status field positions
    localparam int PORT_POWER_ENABLE_CTL_MIRROR_BIT = 6;
    localparam int MODE_TWO_MIRROR_BIT = 5;
    localparam int MODE_ONE_MIRROR_BIT = 4;
    localparam int EMU_EN_MIRROR_BIT = 3;
    localparam int POLARITY_BIT = 2;
    localparam int POWER_STATE_LSB = 0;
    // software override positions inside the switch configuration register
    localparam int PORT_POWER_ENABLE_CTL_SOFT_BIT = 7;
    localparam int MODE_TWO_SOFT_BIT = 6;
    localparam int MODE_ONE_SOFT_BIT = 5;
    localparam int EMU_EN_SOFT_BIT = 4;
    // dedicated-charger data switch control inside the data switch configuration
    localparam int DCHG_DATA_SW_BIT = 0;
    // power state encoding
    typedef enum logic [1:0] {
        PCSR_SLEEP = 2'h0,
        PCSR_DETECT = 2'h1,
        PCSR_ACTIVE = 2'h2,
        PCSR_ERROR = 2'h3
    } pcsr_power_state_t;
endpackage

/* rtl/pcsr_regs.sv */
// status and configuration registers of the port charger controller
// assumes the serial engine presents one-cycle read and write strobes on sys_clk_in,
// and that pins arrive asynchronously and are synchronised here
//
// Contract
// - acceptance bits never drive alert or attach
// - clear acceptance on disable, mode change, removal
// - successful legacy handshake sets bit n-1
// - accepted legacy profile selects dedicated data switch
// - accepted legacy profile selects custom current limit
// - read-only pin status mirrors controls, power state
// - enable bit6, mode2 bit5, mode1 bit4, emulation bit3
// - mirror combines pin with software override
// - polarity decoded at power-up on bit 2
// - power state on bits 1-0, live
// - bus access wakes device, never reads sleep
// - five configuration registers with their defaults
`timescale 1ns/1ps
module pcsr_regs (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // internal register port from the serial engine
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    output logic wake_request_out,
    // external control pins, asynchronous
    input wire logic port_power_enable_ctl_in,
    input wire logic mode_input_one_in,
    input wire logic mode_input_two_in,
    input wire logic emulation_enable_input_in,
    input wire logic polarity_select_in,
    // charger emulation engine and power state machine, same clock
    input wire logic [6:0] legacy_accept_set_in,
    input wire logic active_mode_change_in,
    input wire logic removal_detect_in,
    input wire logic [1:0] power_state_in,
    input wire logic engine_data_switch_in,
    input wire logic [1:0] engine_limit_mode_in,
    input wire logic [1:0] custom_limit_mode_in,
    // effective controls and steering
    output logic port_power_enabled_out,
    output logic mode_one_effective_out,
    output logic mode_two_effective_out,
    output logic emulation_enabled_out,
    output logic legacy_any_accepted_out,
    output logic data_switch_closed_out,
    output logic [1:0] current_limit_mode_out,
    // configuration register contents for the rest of the device
    output logic [7:0] general_config_out,
    output logic [7:0] emulation_config_out,
    output logic [7:0] switch_config_out,
    output logic [7:0] attach_detect_config_out,
    output logic [7:0] data_switch_config_out
);
    // two-flop synchronisers for the five pins; stage one is read only by stage two
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    logic [1:0] settle_q; // counts edges until synced pins are trustworthy
    logic polarity_q; // decoded polarity, caught once after reset
    logic polarity_done_q;
    logic [6:0] accept_q; // legacy acceptance bits
    logic enabled_q; // last cycle's effective enable, for the falling edge
    logic [7:0] general_q;
    logic [7:0] emulation_q;
    logic [7:0] switch_q;
    logic [7:0] attach_q;
    logic [7:0] data_sw_q;
    logic [7:0] rdata_q;
    logic rvalid_q;

    // synchronise the pins; kept at zero through reset
    // bit order: power enable, mode one, mode two, emulation enable, polarity select
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_meta_q <= 5'h00;
            pin_sync_q <= 5'h00;
        end else begin
            pin_meta_q <= {polarity_select_in, emulation_enable_input_in, mode_input_two_in,
                mode_input_one_in, port_power_enable_ctl_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    // mirrors: a software override forces the reported level just as the pin does
    // the override is an OR, so software can force a mirror high but never low
    wire port_power_enable_mirror = pin_sync_q[0] | switch_q[pcsr_pkg::PORT_POWER_ENABLE_CTL_SOFT_BIT];
    wire mode_one_mirror = pin_sync_q[1] | switch_q[pcsr_pkg::MODE_ONE_SOFT_BIT];
    wire mode_two_mirror = pin_sync_q[2] | switch_q[pcsr_pkg::MODE_TWO_SOFT_BIT];
    wire emulation_enable_mirror = pin_sync_q[3] | switch_q[pcsr_pkg::EMU_EN_SOFT_BIT];
    wire polarity_pin = pin_sync_q[4];

    // polarity is caught once, after the synchroniser has filled; a later pin move is ignored
    // limitation: moving the polarity strap after power-up needs a reset to take effect
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            settle_q <= 2'h0;
            polarity_q <= 1'b0;
            polarity_done_q <= 1'b0;
        end else if (!polarity_done_q) begin
            settle_q <= settle_q + 2'h1;
            if (settle_q == 2'h2) begin
                polarity_q <= polarity_pin;
                polarity_done_q <= 1'b1;
            end
        end
    end

    // power switch is enabled when the control level matches the decoded polarity;
    // held off until polarity is known so no false enable glitch reaches the switch
    // a falling enable is the disable event that empties the acceptance byte
    wire enabled = polarity_done_q & (port_power_enable_mirror == polarity_q);
    wire enable_fell = enabled_q & ~enabled;

    // acceptance bits: set wins over a clear in the same cycle so no handshake is lost
    // a clear with no set empties the byte at the next edge, seen at the next read
    wire accept_clear = enable_fell | active_mode_change_in | removal_detect_in;
    wire [6:0] accept_d = (accept_clear ? 7'h00 : accept_q) | legacy_accept_set_in;
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            accept_q <= 7'h00;
            enabled_q <= 1'b0;
        end else begin
            accept_q <= accept_d;
            enabled_q <= enabled;
        end
    end

    // steering while any legacy profile holds; acceptance bits reach no alert or attach logic
    // both selections stay combinational so the switch follows the byte with no extra delay
    wire any_accepted = |accept_q;
    wire data_sw_sel = any_accepted ? data_sw_q[pcsr_pkg::DCHG_DATA_SW_BIT]
                                    : engine_data_switch_in;
    wire [1:0] limit_sel = any_accepted ? custom_limit_mode_in : engine_limit_mode_in;

    // address decode of the register port
    // the two status offsets are matched only in the read path, never for writes
    wire hit_general = reg_addr_in == pcsr_pkg::GENERAL_CFG_OFS;
    wire hit_emulation = reg_addr_in == pcsr_pkg::EMULATION_CFG_OFS;
    wire hit_switch = reg_addr_in == pcsr_pkg::SWITCH_CFG_OFS;
    wire hit_attach = reg_addr_in == pcsr_pkg::ATTACH_CFG_OFS;
    wire hit_data_sw = reg_addr_in == pcsr_pkg::DATA_SW_CFG_OFS;

    // configuration registers; status offsets have no write path at all
    // each byte keeps its value until the next write to its own offset
    // a write to an unmapped or status offset matches no hit and is dropped
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            general_q <= pcsr_pkg::GENERAL_CFG_RST;
            emulation_q <= pcsr_pkg::EMULATION_CFG_RST;
            switch_q <= pcsr_pkg::SWITCH_CFG_RST;
            attach_q <= pcsr_pkg::ATTACH_CFG_RST;
            data_sw_q <= pcsr_pkg::DATA_SW_CFG_RST;
        end else if (reg_write_in) begin
            if (hit_general) general_q <= reg_wdata_in;
            if (hit_emulation) emulation_q <= reg_wdata_in;
            if (hit_switch) switch_q <= reg_wdata_in;
            if (hit_attach) attach_q <= reg_wdata_in;
            if (hit_data_sw) data_sw_q <= reg_wdata_in;
        end
    end

    // the access itself wakes the device, so a read reports detect rather than sleep
    // the live state comes straight from the state machine with no register in between
    wire [1:0] state_seen = (power_state_in == pcsr_pkg::PCSR_SLEEP) ? pcsr_pkg::PCSR_DETECT
                                                                       : power_state_in;
    wire [7:0] pin_status;
    assign pin_status[7] = 1'b0;
    assign pin_status[pcsr_pkg::PORT_POWER_ENABLE_CTL_MIRROR_BIT] = port_power_enable_mirror;
    assign pin_status[pcsr_pkg::MODE_TWO_MIRROR_BIT] = mode_two_mirror;
    assign pin_status[pcsr_pkg::MODE_ONE_MIRROR_BIT] = mode_one_mirror;
    assign pin_status[pcsr_pkg::EMU_EN_MIRROR_BIT] = emulation_enable_mirror;
    assign pin_status[pcsr_pkg::POLARITY_BIT] = polarity_q;
    assign pin_status[pcsr_pkg::POWER_STATE_LSB +: 2] = state_seen;

    // read multiplexer; unmapped offsets read as zero
    // a priority chain, but the offsets are distinct so the order changes nothing
    wire [7:0] read_mux =
        (reg_addr_in == pcsr_pkg::LEGACY_ACCEPT_OFS) ? {1'b0, accept_q} :
        (reg_addr_in == pcsr_pkg::PIN_STATE_OFS) ? pin_status :
        hit_general ? general_q :
        hit_emulation ? emulation_q :
        hit_switch ? switch_q :
        hit_attach ? attach_q :
        hit_data_sw ? data_sw_q : 8'h00;

    // read data is registered and valid one cycle after the strobe
    // rdata holds the last byte read until the next strobe, which saves a clear path
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_read_in;
            if (reg_read_in) rdata_q <= read_mux;
        end
    end

    // outputs
    // steering and mirrors are combinational; register contents come from flops
    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;
    assign wake_request_out = reg_read_in | reg_write_in;
    assign port_power_enabled_out = enabled;
    assign mode_one_effective_out = mode_one_mirror;
    assign mode_two_effective_out = mode_two_mirror;
    assign emulation_enabled_out = emulation_enable_mirror;
    assign legacy_any_accepted_out = any_accepted;
    assign data_switch_closed_out = data_sw_sel;
    assign current_limit_mode_out = limit_sel;
    assign general_config_out = general_q;
    assign emulation_config_out = emulation_q;
    assign switch_config_out = switch_q;
    assign attach_detect_config_out = attach_q;
    assign data_switch_config_out = data_sw_q;

    // checks on the logic above
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    // acceptance clearing: each of the three events empties the byte unless a set coincides
    a_clear_on_removal: assert property (
        removal_detect_in && legacy_accept_set_in == 7'h00 |=> accept_q == 7'h00)
        else $error("acceptance bits survived a removal");
    a_clear_on_disable: assert property (
        $fell(enabled) && !active_mode_change_in && legacy_accept_set_in == 7'h00
        |-> ##1 accept_q == 7'h00)
        else $error("acceptance bits survived a disable");
    a_clear_on_mode: assert property (
        active_mode_change_in && legacy_accept_set_in == 7'h00 |=> accept_q == 7'h00)
        else $error("acceptance bits survived an active mode change");
    // acceptance setting: a legacy one handshake sticks, and with no event nothing else moves
    a_set_on_accept: assert property (
        legacy_accept_set_in[0] |=> accept_q[0])
        else $error("legacy one handshake not recorded");
    a_accept_hold: assert property (
        !accept_clear && legacy_accept_set_in == 7'h00 |=> $stable(accept_q))
        else $error("acceptance bits moved with no event");
    // steering: an accepted profile picks the configured sources, otherwise the engine's
    a_data_switch_steer: assert property (
        legacy_any_accepted_out |-> data_switch_closed_out == data_sw_q[0])
        else $error("data switch not taken from dedicated charger bit");
    a_data_switch_idle: assert property (
        !legacy_any_accepted_out |-> data_switch_closed_out == engine_data_switch_in)
        else $error("data switch not left to the engine");
    a_limit_steer: assert property (
        legacy_any_accepted_out |-> current_limit_mode_out == custom_limit_mode_in)
        else $error("current limit not custom while accepted");
    a_limit_idle: assert property (
        !legacy_any_accepted_out |-> current_limit_mode_out == engine_limit_mode_in)
        else $error("current limit not left to the engine");
    // read port: one valid pulse per strobe, and none without one
    a_rvalid_follows: assert property (
        reg_read_in |=> reg_rvalid_out)
        else $error("read strobe gave no valid");
    a_rvalid_single: assert property (
        !reg_read_in |=> !reg_rvalid_out)
        else $error("valid without a read strobe");
    // pin status reads: mirrors, polarity and a state field that never shows sleep
    a_pin_read_back: assert property (
        reg_read_in && reg_addr_in == pcsr_pkg::PIN_STATE_OFS
        |=> reg_rvalid_out && reg_rdata_out[5:3] == $past(pin_status[5:3]))
        else $error("pin status read returned stale mirrors");
    a_enable_read_back: assert property (
        reg_read_in && reg_addr_in == pcsr_pkg::PIN_STATE_OFS
        |=> reg_rdata_out[7:6] == {1'b0, $past(port_power_enable_mirror)})
        else $error("enable mirror or spare bit misread");
    a_override_mirror: assert property (
        switch_q[pcsr_pkg::MODE_ONE_SOFT_BIT] |-> mode_one_effective_out)
        else $error("mode one override not reflected");
    a_polarity_hold: assert property (
        polarity_done_q |=> $stable(polarity_q))
        else $error("polarity changed after power-up decode");
    a_enable_held_off: assert property (
        !polarity_done_q |-> !port_power_enabled_out)
        else $error("switch enabled before polarity was known");
    a_polarity_read: assert property (
        reg_read_in && reg_addr_in == pcsr_pkg::PIN_STATE_OFS
        |=> reg_rdata_out[pcsr_pkg::POLARITY_BIT] == $past(polarity_q))
        else $error("polarity bit misread");
    a_state_live: assert property (
        reg_read_in && reg_addr_in == pcsr_pkg::PIN_STATE_OFS && power_state_in != 2'h0
        |=> reg_rdata_out[1:0] == $past(power_state_in))
        else $error("power state field not live");
    a_state_never_sleep: assert property (
        reg_read_in && reg_addr_in == pcsr_pkg::PIN_STATE_OFS
        |=> reg_rdata_out[1:0] != 2'h0)
        else $error("power state read as sleep");
    a_wake_on_access: assert property (
        reg_read_in || reg_write_in |-> wake_request_out)
        else $error("access did not request a wake");
    // register port: switch, general and data switch writes land; a pin status write leaves switch and general alone
    a_config_write: assert property (
        reg_write_in && hit_switch |=> switch_config_out == $past(reg_wdata_in))
        else $error("switch configuration write lost");
    a_config_general: assert property (
        reg_write_in && hit_general |=> general_config_out == $past(reg_wdata_in))
        else $error("general configuration write lost");
    a_config_data_sw: assert property (
        reg_write_in && hit_data_sw |=> data_switch_config_out == $past(reg_wdata_in))
        else $error("data switch configuration write lost");
    a_status_write_ignored: assert property (
        reg_write_in && reg_addr_in == pcsr_pkg::PIN_STATE_OFS
        |=> $stable(switch_q) && $stable(general_q))
        else $error("status write disturbed a register");

    // main scenarios worth seeing at least once
    c_accept_then_clear: cover property (accept_q != 7'h00 ##[1:20] accept_q == 7'h00);
    c_set_and_clear_same: cover property (removal_detect_in && legacy_accept_set_in != 7'h00);
    c_read_active: cover property (reg_rvalid_out && reg_rdata_out[1:0] == 2'h2);
    c_config_write: cover property (reg_write_in && hit_data_sw);
    c_disable_clear: cover property (enable_fell && accept_q != 7'h00);
endmodule

/* testbench/pcsr_host_model.sv */
// host side of the register port: single-byte reads and writes on request
// assumes the bench calls its tasks and that strobes change at the falling edge
`timescale 1ns/1ps
module pcsr_host_model (
    input wire logic sys_clk_in,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rvalid_in,
    output logic [7:0] reg_addr_out,
    output logic reg_write_out,
    output logic reg_read_out,
    output logic [7:0] reg_wdata_out
);
    // idle bus at time zero, no strobe before reset release
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_write_out = 1'b0;
        reg_read_out = 1'b0;
    end
    // one-cycle write strobe; every access doubles as a wake request
    task automatic host_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_write_out = 1'b1;
        @(negedge sys_clk_in);
        reg_write_out = 1'b0;
    endtask
    // read data is taken in the one cycle that valid stands
    task automatic host_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk_in);
        reg_addr_out = a;
        reg_read_out = 1'b1;
        @(negedge sys_clk_in);
        reg_read_out = 1'b0;
        // a missing valid poisons the data so the compare fails
        d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hxx;
    endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the charger status register slice
// assumes the host model drives the register port; pins change at the falling edge
`timescale 1ns/1ps
module tb_top;
    logic sys_clk_in, rstn_in, reg_write_in, reg_read_in, reg_rvalid_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, data_switch_config_out;
    logic port_power_enable_ctl_in, mode_input_one_in, mode_input_two_in;
    logic emulation_enable_input_in, polarity_select_in, active_mode_change_in;
    logic removal_detect_in, engine_data_switch_in, port_power_enabled_out;
    logic legacy_any_accepted_out, data_switch_closed_out, wake_request_out;
    logic mode_one_effective_out, mode_two_effective_out, emulation_enabled_out;
    logic [7:0] general_config_out, emulation_config_out, switch_config_out;
    logic [7:0] attach_detect_config_out;
    logic [6:0] legacy_accept_set_in;
    logic [1:0] power_state_in, engine_limit_mode_in, custom_limit_mode_in, current_limit_mode_out;
    logic [7:0] d, v, ofs [5], cfg [5];
    logic [3:0] s;
    int num_errors = 0, total_checks = 0, cycles = 0;
    pcsr_regs dut (.sys_clk_in, .rstn_in, .reg_addr_in, .reg_write_in, .reg_read_in,
        .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .wake_request_out,
        .port_power_enable_ctl_in, .mode_input_one_in, .mode_input_two_in,
        .emulation_enable_input_in, .polarity_select_in, .legacy_accept_set_in,
        .active_mode_change_in, .removal_detect_in, .power_state_in, .engine_data_switch_in,
        .engine_limit_mode_in, .custom_limit_mode_in, .port_power_enabled_out,
        .mode_one_effective_out, .mode_two_effective_out, .emulation_enabled_out,
        .legacy_any_accepted_out, .data_switch_closed_out, .current_limit_mode_out,
        .general_config_out, .emulation_config_out, .switch_config_out,
        .attach_detect_config_out, .data_switch_config_out);
    pcsr_host_model host (.sys_clk_in, .reg_rdata_in(reg_rdata_out),
        .reg_rvalid_in(reg_rvalid_out), .reg_addr_out(reg_addr_in),
        .reg_write_out(reg_write_in), .reg_read_out(reg_read_in),
        .reg_wdata_out(reg_wdata_in));
    // 200 MHz clock
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // every access must raise the wake request while its strobe stands
    always @(posedge sys_clk_in)
        if (reg_read_in || reg_write_in) check({7'h0, wake_request_out}, 8'h01);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // pulse one clearing event for a single cycle: removal, or else a new active mode
    task automatic pulse(input logic removal);
        @(negedge sys_clk_in);
        if (removal) removal_detect_in = 1'b1;
        else active_mode_change_in = 1'b1;
        @(negedge sys_clk_in);
        removal_detect_in = 1'b0;
        active_mode_change_in = 1'b0;
    endtask
    initial begin
        void'($urandom(32'he9f9561c));
        ofs = '{pcsr_pkg::GENERAL_CFG_OFS, pcsr_pkg::EMULATION_CFG_OFS,
            pcsr_pkg::SWITCH_CFG_OFS, pcsr_pkg::ATTACH_CFG_OFS, pcsr_pkg::DATA_SW_CFG_OFS};
        cfg = '{8'h01, 8'h8c, 8'h04, 8'h46, 8'h14};
        {rstn_in, active_mode_change_in, removal_detect_in, legacy_accept_set_in} = '0;
        {mode_input_one_in, mode_input_two_in, emulation_enable_input_in} = '0;
        {power_state_in, engine_data_switch_in, engine_limit_mode_in} = '0;
        custom_limit_mode_in = 2'h0;
        polarity_select_in = 1'($urandom);
        port_power_enable_ctl_in = polarity_select_in;
        repeat (3) @(posedge sys_clk_in);
        @(negedge sys_clk_in) rstn_in = 1'b1;
        repeat (5) @(negedge sys_clk_in);
        // reset values, then write and readback of each configuration byte, random except zero for the switch byte
        for (int i = 0; i < 5; i++) begin
            host.host_read(ofs[i], d);
            check(d, cfg[i]);
            cfg[i] = (i == 2) ? 8'h00 : 8'($urandom);
            host.host_write(ofs[i], cfg[i]);
        end
        for (int i = 0; i < 5; i++) begin
            host.host_read(ofs[i], d);
            check(d, cfg[i]);
        end
        check(data_switch_config_out, cfg[4]);
        check(general_config_out, cfg[0]);
        check(emulation_config_out, cfg[1]);
        check(switch_config_out, cfg[2]);
        check(attach_detect_config_out, cfg[3]);
        host.host_read(8'h30, d);
        check(d, 8'h00);
        // pin mirrors with random overrides; writes to the status byte must not stick
        for (int i = 0; i < 8; i++) begin
            s = 4'($urandom);
            host.host_write(pcsr_pkg::SWITCH_CFG_OFS, {s, 4'h0});
            @(negedge sys_clk_in);
            {port_power_enable_ctl_in, mode_input_two_in, mode_input_one_in} = 3'($urandom);
            emulation_enable_input_in = 1'($urandom);
            power_state_in = 2'($urandom);
            host.host_write(pcsr_pkg::PIN_STATE_OFS, 8'hff);
            repeat (3) @(negedge sys_clk_in);
            v = {1'b0, port_power_enable_ctl_in | s[3], mode_input_two_in | s[2],
                mode_input_one_in | s[1], emulation_enable_input_in | s[0], polarity_select_in,
                (power_state_in == 2'h0) ? 2'h1 : power_state_in};
            host.host_read(pcsr_pkg::PIN_STATE_OFS, d);
            check(d, v);
            check({7'h0, port_power_enabled_out}, {7'h0, v[6] == polarity_select_in});
            d = {5'h0, mode_two_effective_out, mode_one_effective_out, emulation_enabled_out};
            check(d, {5'h0, v[5:3]});
        end
        host.host_write(pcsr_pkg::SWITCH_CFG_OFS, 8'h00);
        @(negedge sys_clk_in) port_power_enable_ctl_in = polarity_select_in;
        // each profile accepted in turn, then cleared by one of the three events in rotation
        for (int n = 0; n < 7; n++) begin
            custom_limit_mode_in = 2'($urandom);
            engine_limit_mode_in = ~custom_limit_mode_in;
            engine_data_switch_in = ~cfg[4][0];
            repeat (4) @(negedge sys_clk_in);
            legacy_accept_set_in = 7'h01 << n;
            @(negedge sys_clk_in) legacy_accept_set_in = 7'h00;
            host.host_write(pcsr_pkg::LEGACY_ACCEPT_OFS, 8'h00);
            host.host_read(pcsr_pkg::LEGACY_ACCEPT_OFS, d);
            check(d, 8'h01 << n);
            check({7'h0, legacy_any_accepted_out}, 8'h01);
            check({7'h0, data_switch_closed_out}, {7'h0, cfg[4][0]});
            check({6'h0, current_limit_mode_out}, {6'h0, custom_limit_mode_in});
            check(attach_detect_config_out, cfg[3]);
            if (n % 3 == 0) pulse(1'b1);
            else if (n % 3 == 1) pulse(1'b0);
            else begin
                port_power_enable_ctl_in = ~polarity_select_in;
                repeat (4) @(negedge sys_clk_in);
                port_power_enable_ctl_in = polarity_select_in;
            end
            host.host_read(pcsr_pkg::LEGACY_ACCEPT_OFS, d);
            check(d, 8'h00);
            check({7'h0, data_switch_closed_out}, {7'h0, engine_data_switch_in});
            check({6'h0, current_limit_mode_out}, {6'h0, engine_limit_mode_in});
        end
        tally_and_finish();
    end
endmodule
